//--- logic/hbs_top.sv
// Notes on behaviour
// R1 - Sequencing only when sequence enable set
// R2 - Lift pulse inhibit, hold minimum frequency first
// R3 - Standstill until release delay elapses, then ramp
// R4 - Ramp or fast stop: hold at minimum, then clear
// R5 - Coast stop clears brake status immediately
// R6 - Brake status is status word bit 12
// R7 - Status to digital output or serial link
// R8 - Routing alone does not enable brake control
// R9 - Release delay covers brake opening plus relay
// R10 - Hold time covers brake closing plus relay
// R11 - Brake output polarity must not be inverted; CTRL_INVERT_BIT inverts it
// R12 - Millisecond counters loaded at phase start
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module hbs_top #(
	parameter int TICK_CYCLES = hbs_pkg::TICK_CYCLES,
	parameter int TIME_WIDTH  = 16
) (
	input  wire logic                core_clk_i,
	input  wire logic                rst_n_i,
	// AXI4-Lite slave
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Drive sequence side
	input  wire hbs_pkg::hbs_cmd_s   cmd_i,
	output hbs_pkg::hbs_drive_s      drive_o,
	output logic [15:0]              drive_status_word_o,
	output logic                     brake_output_o
);

	if (TIME_WIDTH < 2 || TIME_WIDTH > 16) begin : g_bad_width
		$error("TIME_WIDTH must be 2..16");
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [31:0]           ctrl_q;
	logic [TIME_WIDTH-1:0] release_q;
	logic [TIME_WIDTH-1:0] hold_q;
	logic [15:0]           min_freq_q;

	logic       aw_held_q;
	logic [7:0] aw_addr_q;
	logic       w_held_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic       bvalid_q;
	logic [1:0] bresp_q;
	logic       rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == hbs_pkg::ADDR_CTRL || a == hbs_pkg::ADDR_RELEASE ||
			a == hbs_pkg::ADDR_HOLD || a == hbs_pkg::ADDR_MIN_FREQ ||
			a == hbs_pkg::ADDR_STATUS;
	endfunction

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	wire   aw_take       = s_axi_awvalid && s_axi_awready;
	wire   w_take        = s_axi_wvalid && s_axi_wready;
	wire   aw_have       = aw_held_q || aw_take;
	wire   w_have        = w_held_q || w_take;
	wire   wr_do         = aw_have && w_have && !bvalid_q;
	wire [7:0]  wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr;
	wire [31:0] wr_data  = w_held_q ? w_data_q : s_axi_wdata;
	wire [3:0]  wr_strb  = w_held_q ? w_strb_q : s_axi_wstrb;
	wire   wr_ok         = mapped(wr_addr);

	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	wire   ar_take       = s_axi_arvalid && !rvalid_q;

	wire [31:0] ctrl_new  = merge(ctrl_q, wr_data, wr_strb);
	wire [31:0] rel_new   = merge(32'(release_q), wr_data, wr_strb);
	wire [31:0] hold_new  = merge(32'(hold_q), wr_data, wr_strb);
	wire [31:0] minf_new  = merge({16'h0000, min_freq_q}, wr_data, wr_strb);

	// Write is answered one cycle after both halves are in, in either order
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= hbs_pkg::AXI_OKAY;
		end else begin
			if (aw_take && !wr_do) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_take && !wr_do) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? hbs_pkg::AXI_OKAY : hbs_pkg::AXI_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl_q     <= hbs_pkg::RST_CTRL;
			release_q  <= TIME_WIDTH'(hbs_pkg::RST_RELEASE);
			hold_q     <= TIME_WIDTH'(hbs_pkg::RST_HOLD);
			min_freq_q <= hbs_pkg::RST_MIN_FREQ;
		end else if (wr_do) begin
			unique case (wr_addr)
				hbs_pkg::ADDR_CTRL:     ctrl_q <= ctrl_new & 32'h0000_0007;
				hbs_pkg::ADDR_RELEASE:  release_q <= rel_new[TIME_WIDTH-1:0];
				hbs_pkg::ADDR_HOLD:     hold_q <= hold_new[TIME_WIDTH-1:0];
				hbs_pkg::ADDR_MIN_FREQ: min_freq_q <= minf_new[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Brake sequence
	// ------------------------------------------------------------
	wire seq_enable = ctrl_q[hbs_pkg::CTRL_ENABLE_BIT];
	wire route_out  = ctrl_q[hbs_pkg::CTRL_ROUTE_BIT];
	wire invert_out = ctrl_q[hbs_pkg::CTRL_INVERT_BIT];

	hbs_pkg::hbs_state_e state_q;
	hbs_pkg::hbs_state_e state_d;
	logic                brake_released;
	logic                timer_load;
	logic [TIME_WIDTH-1:0] timer_value;
	logic                tick;
	logic                timer_done;

	// ------------------------------------------------------------
	// Millisecond timing
	// ------------------------------------------------------------
	// Divider runs free, so the first tick of a phase may come early
	hbs_tick #(
		.CYCLES (TICK_CYCLES)
	) i_hbs_tick (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.tick_o     (tick)
	);

	hbs_ms_timer #(
		.WIDTH (TIME_WIDTH)
	) i_hbs_ms_timer (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.load_i     (timer_load),
		.value_i    (timer_value),
		.tick_i     (tick), // R12
		.done_o     (timer_done)
	);

	wire stop_req = cmd_i.ramp_stop || cmd_i.fast_stop || !cmd_i.run;

	always_comb begin
		state_d     = state_q;
		timer_load  = 1'b0;
		timer_value = release_q;
		unique case (state_q)
			hbs_pkg::ST_IDLE: begin
				if (seq_enable && cmd_i.run && !cmd_i.coast_stop && !stop_req) begin
					state_d     = hbs_pkg::ST_RELEASE;
					timer_load  = 1'b1; // R12
					timer_value = release_q; // R3
				end
			end
			hbs_pkg::ST_RELEASE: begin
				// A stop before the wait ends closes the brake; no ramp has begun
				if (timer_done) state_d = hbs_pkg::ST_RUN; // R3
				else if (stop_req) state_d = hbs_pkg::ST_IDLE;
			end
			hbs_pkg::ST_RUN: begin
				if (stop_req && cmd_i.at_min_freq) begin
					state_d     = hbs_pkg::ST_HOLD; // R4
					timer_load  = 1'b1; // R12
					timer_value = hold_q;
				end
			end
			hbs_pkg::ST_HOLD: begin
				if (timer_done) state_d = hbs_pkg::ST_IDLE; // R4
			end
			default: state_d = hbs_pkg::ST_IDLE;
		endcase
		// Coast stop and disable override every state
		if (cmd_i.coast_stop || !seq_enable) begin
			state_d    = hbs_pkg::ST_IDLE; // R5
			timer_load = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) state_q <= hbs_pkg::ST_IDLE;
		else state_q <= state_d;
	end

	// ------------------------------------------------------------
	// Status and outputs
	// ------------------------------------------------------------

	// Status is registered so the relay line never glitches on decode
	logic       brake_q;
	logic [15:0] drive_word_q;
	hbs_pkg::hbs_drive_s drive_q;
	logic       out_q;

	assign brake_released = (state_d == hbs_pkg::ST_RUN ||
		state_d == hbs_pkg::ST_HOLD ||
		state_d == hbs_pkg::ST_RELEASE) && seq_enable; // R1

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			brake_q      <= 1'b0;
			drive_q      <= '0;
			drive_word_q <= 16'h0000;
			out_q        <= 1'b0;
		end else begin
			brake_q <= brake_released;
			drive_q.pulse_enable <= (state_d != hbs_pkg::ST_IDLE); // R2
			drive_q.ramp_enable  <= (state_d == hbs_pkg::ST_RUN); // R3
			drive_q.freq_floor   <= min_freq_q; // R2
			drive_word_q <= 16'h0000;
			drive_word_q[hbs_pkg::STATUS_BRAKE_BIT] <= brake_released; // R6
			// Route alone gives nothing unless invert is set: status already gated by enable
			out_q <= route_out && (brake_released ^ invert_out); // R7 R8 R11
		end
	end

	assign drive_o             = drive_q;
	assign drive_status_word_o = drive_word_q; // R7
	assign brake_output_o      = out_q;

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire [31:0] status_rd = {16'h0000, drive_word_q} |
		(32'(drive_q.pulse_enable) << hbs_pkg::STATUS_PULSE_BIT) |
		(32'(drive_q.ramp_enable) << hbs_pkg::STATUS_RAMP_BIT) |
		(32'(state_q) << hbs_pkg::STATUS_STATE_LSB);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= hbs_pkg::AXI_OKAY;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= mapped(s_axi_araddr) ? hbs_pkg::AXI_OKAY : hbs_pkg::AXI_SLVERR;
			unique case (s_axi_araddr)
				hbs_pkg::ADDR_CTRL:     rdata_q <= ctrl_q;
				hbs_pkg::ADDR_RELEASE:  rdata_q <= 32'(release_q);
				hbs_pkg::ADDR_HOLD:     rdata_q <= 32'(hold_q);
				hbs_pkg::ADDR_MIN_FREQ: rdata_q <= {16'h0000, min_freq_q};
				hbs_pkg::ADDR_STATUS:   rdata_q <= status_rd;
				default:                rdata_q <= 32'h0000_0000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule

//--- include/hbs_pkg.sv
package hbs_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_RELEASE  = 8'h04;
	localparam logic [7:0] ADDR_HOLD     = 8'h08;
	localparam logic [7:0] ADDR_MIN_FREQ = 8'h0C;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT    = 0;
	localparam int CTRL_ROUTE_BIT     = 1;
	localparam int CTRL_INVERT_BIT    = 2;
	localparam int STATUS_BRAKE_BIT   = 12;
	localparam int STATUS_PULSE_BIT   = 0;
	localparam int STATUS_RAMP_BIT    = 1;
	localparam int STATUS_STATE_LSB   = 4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
	localparam logic [15:0] RST_RELEASE  = 16'h0064;
	localparam logic [15:0] RST_HOLD     = 16'h0064;
	localparam logic [15:0] RST_MIN_FREQ = 16'h0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_FREQ_HZ   = 100_000_000;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES   = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RELEASE,
		ST_RUN,
		ST_HOLD
	} hbs_state_e;

	typedef struct packed {
		logic run;
		logic ramp_stop;
		logic fast_stop;
		logic coast_stop;
		logic at_min_freq;
	} hbs_cmd_s;

	typedef struct packed {
		logic        pulse_enable;
		logic        ramp_enable;
		logic [15:0] freq_floor;
	} hbs_drive_s;

endpackage

//--- logic/hbs_tick.sv
`timescale 1ns/1ps
module hbs_tick #(
	parameter int CYCLES = hbs_pkg::TICK_CYCLES
) (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	output logic      tick_o
);

	if (CYCLES < 1) begin : g_bad_cycles
		$error("CYCLES must be at least 1");
	end

	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	wire          wrap = (cnt_q == W'(CYCLES - 1));

	assign cnt_d  = wrap ? '0 : cnt_q + W'(1);
	assign tick_o = wrap;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) cnt_q <= '0;
		else cnt_q <= cnt_d;
	end

endmodule

//--- logic/hbs_ms_timer.sv
`timescale 1ns/1ps
module hbs_ms_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] value_i,
	input  wire logic             tick_i,
	output logic                  done_o
);

	if (WIDTH < 2) begin : g_bad_width
		$error("WIDTH must be at least 2");
	end

	logic [WIDTH-1:0] cnt_q;

	// Done when loaded value has been counted out in ms ticks
	assign done_o = (cnt_q == '0) && !load_i;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) cnt_q <= '0;
		else if (load_i) cnt_q <= value_i;
		else if (tick_i && cnt_q != '0) cnt_q <= cnt_q - WIDTH'(1);
	end

endmodule

//--- bench/hbs_top_sva.sv
`timescale 1ns/1ps
module hbs_top_sva (
	input  wire logic               core_clk_i,
	input  wire logic               rst_n_i,
	input  wire hbs_pkg::hbs_cmd_s  cmd_i,
	input  wire hbs_pkg::hbs_drive_s drive_o,
	input  wire logic [15:0]        drive_status_word_o,
	input  wire logic               brake_output_o
);
	logic brk;
	assign brk = drive_status_word_o[hbs_pkg::STATUS_BRAKE_BIT];
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_running;
		brk && drive_o.ramp_enable;
	endsequence
	sequence s_stop_min;
		(cmd_i.ramp_stop || cmd_i.fast_stop) && cmd_i.at_min_freq && !cmd_i.coast_stop;
	endsequence
	a_reset_idle: assert property (disable iff (1'b0) !rst_n_i |=> !brk && !brake_output_o)
		else $error("brake open after reset");
	a_release_current: assert property (brk |-> drive_o.pulse_enable)
		else $error("brake open without holding current");
	a_pulse_with_brake: assert property ($rose(brk) |-> $rose(drive_o.pulse_enable))
		else $error("pulses not lifted with brake release");
	a_ramp_needs_brake: assert property (drive_o.ramp_enable |-> brk)
		else $error("ramp with brake closed");
	a_ramp_after_wait: assert property ($rose(drive_o.ramp_enable) |-> $past(brk))
		else $error("ramp began without release wait");
	a_hold_at_min: assert property (s_running ##0 s_stop_min |=> brk && drive_o.pulse_enable)
		else $error("brake closed without hold time");
	a_coast_clear: assert property (cmd_i.coast_stop |=> !brk && !brake_output_o)
		else $error("brake not closed after coast stop");
	a_output_tracks: assert property (brake_output_o |-> brk)
		else $error("brake output without status bit");
	a_status_bit: assert property ($rose(brake_output_o) |-> $rose(brk))
		else $error("brake output not aligned to status bit");
endmodule
bind hbs_top hbs_top_sva i_hbs_top_sva (
	.core_clk_i         (core_clk_i),
	.rst_n_i            (rst_n_i),
	.cmd_i              (cmd_i),
	.drive_o            (drive_o),
	.drive_status_word_o(drive_status_word_o),
	.brake_output_o     (brake_output_o)
);

//--- bench/hbs_brake_relay.sv
`timescale 1ns/1ps
// Relay contact follows the coil only after it has been stable for DELAY cycles
module hbs_brake_relay #(
	parameter int DELAY = 3
) (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic coil_i,
	output logic      contact_o
);
	int cnt_q;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i || contact_o == coil_i) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			contact_o <= 1'b0;
		end else if (cnt_q >= DELAY - 1 && contact_o != coil_i) begin
			contact_o <= coil_i;
		end
	end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int TICK = 10;
	logic                core_clk = 1'b0;
	logic                rst_n    = 1'b0;
	logic [7:0]          awaddr   = 8'h00;
	logic [7:0]          araddr   = 8'h00;
	logic [31:0]         wdata    = 32'h0000_0000;
	logic                awvalid  = 1'b0;
	logic                wvalid   = 1'b0;
	logic                bready   = 1'b0;
	logic                arvalid  = 1'b0;
	logic                rready   = 1'b0;
	logic                awready, wready, bvalid, arready, rvalid, brake_out, contact;
	logic [1:0]          bresp, rresp;
	logic [31:0]         rdata, d;
	logic [15:0]         stat;
	hbs_pkg::hbs_cmd_s   cmd      = '0;
	hbs_pkg::hbs_drive_s drv;
	int                  err_count = 0;
	int                  compares  = 0;
	int                  n;

	always #5 core_clk = ~core_clk;

	hbs_top #(.TICK_CYCLES(TICK)) i_hbs_top (
		.core_clk_i(core_clk), .rst_n_i(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_i(cmd), .drive_o(drv),
		.drive_status_word_o(stat), .brake_output_o(brake_out));
	hbs_brake_relay i_hbs_brake_relay (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .coil_i(brake_out), .contact_o(contact));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic hang(input int k, input int lim);
		if (k >= lim) begin
			err_count++;
			final_report();
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int k;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		hang(k, 50);
		chk("bresp", bresp, er);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
		int k;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		hang(k, 50);
		d = rdata;
		chk("rresp", rresp, er);
		rready <= 1'b0;
	endtask
	// Counts edges until the brake bit, or the ramp enable, reaches val
	task automatic wait_for(input bit ramp, input logic val, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge core_clk);
			if ((ramp ? drv.ramp_enable : stat[hbs_pkg::STATUS_BRAKE_BIT]) === val) break;
		end
		hang(n, lim);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		axi_rd(hbs_pkg::ADDR_CTRL, hbs_pkg::AXI_OKAY);
		chk("ctrl_reset", d, hbs_pkg::RST_CTRL);
		axi_rd(hbs_pkg::ADDR_RELEASE, hbs_pkg::AXI_OKAY);
		chk("release_reset", d, {16'h0000, hbs_pkg::RST_RELEASE});
		axi_rd(hbs_pkg::ADDR_HOLD, hbs_pkg::AXI_OKAY);
		chk("hold_reset", d, {16'h0000, hbs_pkg::RST_HOLD});
		axi_rd(8'h14, hbs_pkg::AXI_SLVERR);
		chk("unmapped_data", d, 32'h0000_0000);
		axi_wr(8'h18, 32'h0000_0001, hbs_pkg::AXI_SLVERR);
		axi_wr(hbs_pkg::ADDR_RELEASE, 32'h0000_0003, hbs_pkg::AXI_OKAY);
		axi_wr(hbs_pkg::ADDR_HOLD, 32'h0000_0002, hbs_pkg::AXI_OKAY);
		axi_wr(hbs_pkg::ADDR_MIN_FREQ, 32'h0000_0005, hbs_pkg::AXI_OKAY);
		axi_wr(hbs_pkg::ADDR_CTRL, 32'h0000_0002, hbs_pkg::AXI_OKAY);
	endtask
	task automatic t_disabled();
		cmd.run <= 1'b1;
		repeat (30) @(posedge core_clk);
		chk("brk_disabled", stat[12], 1'b0);
		chk("out_disabled", brake_out, 1'b0);
		cmd.run <= 1'b0;
		axi_wr(hbs_pkg::ADDR_CTRL, 32'h0000_0003, hbs_pkg::AXI_OKAY);
	endtask
	task automatic run_up();
		cmd <= '{run: 1'b1, default: 1'b0};
		wait_for(1'b0, 1'b1, 10);
		chk("pulse_at_release", drv.pulse_enable, 1'b1);
		chk("floor_at_release", drv.freq_floor, 16'h0005);
		chk("ramp_at_release", drv.ramp_enable, 1'b0);
		wait_for(1'b1, 1'b1, 40);
		chk("release_wait", n >= 19 && n <= 33, 1'b1);
		chk("relay_open", contact, 1'b1);
		axi_rd(hbs_pkg::ADDR_STATUS, hbs_pkg::AXI_OKAY);
		chk("status_brake", d[12], 1'b1);
	endtask
	task automatic t_stops();
		for (int i = 0; i < 2; i++) begin
			run_up();
			cmd <= '{run: 1'b1, ramp_stop: (i == 0), fast_stop: (i == 1),
				at_min_freq: 1'b1, default: 1'b0};
			wait_for(1'b0, 1'b0, 40);
			chk("hold_wait", n >= 10 && n <= 24, 1'b1);
			chk("out_closed", brake_out, 1'b0);
			cmd <= '0;
			repeat (3) @(posedge core_clk);
			chk("relay_closed", contact, 1'b0);
		end
	endtask
	task automatic t_coast();
		for (int i = 0; i < 2; i++) begin
			if (i == 0) run_up();
			else begin
				cmd.run <= 1'b1;
				wait_for(1'b0, 1'b1, 10);
			end
			cmd.coast_stop <= 1'b1;
			repeat (2) @(posedge core_clk);
			chk("coast_brk", stat[hbs_pkg::STATUS_BRAKE_BIT], 1'b0);
			chk("coast_out", brake_out, 1'b0);
			cmd <= '0;
			@(posedge core_clk);
		end
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_disabled();
		t_stops();
		t_coast();
		final_report();
	end
endmodule
